// >>> dcs_pkg.sv
// dcs_pkg: register map, field positions, reset values and states of the command-mode sequencer
// assumes a 32-bit apb slave; the link side is abstracted to event and request strobes
package dcs_pkg;

	// register byte offsets
	localparam logic [7:0] DCS_OFF_CMD_HDR   = 8'h00;
	localparam logic [7:0] DCS_OFF_LP_MSG    = 8'h04;
	localparam logic [7:0] DCS_OFF_RX_HDR    = 8'h08;
	localparam logic [7:0] DCS_OFF_RX_PYLD   = 8'h0C;
	localparam logic [7:0] DCS_OFF_RX_CTL    = 8'h10;
	localparam logic [7:0] DCS_OFF_FRM_CTL0  = 8'h14;
	localparam logic [7:0] DCS_OFF_FRM_CTL1  = 8'h18;
	localparam logic [7:0] DCS_OFF_FUNC_CTL  = 8'h1C;
	localparam logic [7:0] DCS_OFF_TRANS_CFG = 8'h20;
	localparam logic [7:0] DCS_OFF_IMR       = 8'h24;
	localparam logic [7:0] DCS_OFF_IIR       = 8'h28;

	// link function control fields
	localparam int DCS_FC_TE_GPIO   = 0;
	localparam int DCS_FC_GATING    = 1;
	localparam int DCS_FC_CMD_MODE  = 2;
	localparam int DCS_FC_DUAL_LINK = 3;

	// frame control fields
	localparam int DCS_FR_REQ      = 0;
	localparam int DCS_FR_PERIODIC = 1;
	localparam int DCS_FR_IN_PROG  = 2;

	// transcoder config fields
	localparam int DCS_TC_ENABLE = 0;
	localparam int DCS_TC_STATE  = 1;

	// receive control fields
	localparam int DCS_RC_NO_UNLOAD = 0;
	localparam int DCS_RC_COUNT_LSB = 8;

	// low power message fields
	localparam int DCS_LP_BTA = 0;

	// interrupt bits above the 16 panel error bits
	localparam int DCS_IRQ_RX_TRIG = 16;
	localparam int DCS_IRQ_RX_DATA = 17;

	// reset values
	localparam logic [31:0] DCS_IMR_RESET  = 32'hFFFFFFFF;
	localparam logic [31:0] DCS_ZERO_RESET = 32'h00000000;

	// queue depths
	localparam int DCS_TXQ_DEPTH = 8;
	localparam int DCS_RXQ_DEPTH = 16;

	// command queue entry: bit 32 marks a turn-around request
	localparam int DCS_TXQ_WIDTH = 33;

	typedef enum logic [2:0] {
		DCS_ST_OFF      = 3'b000,
		DCS_ST_IDLE     = 3'b001,
		DCS_ST_WAIT_TE  = 3'b010,
		DCS_ST_WAIT_BTA = 3'b011,
		DCS_ST_SEND     = 3'b100,
		DCS_ST_VIDEO    = 3'b101
	} dcs_state_t;

endpackage

// >>> dcs_fifo.sv
// dcs_fifo: small synchronous queue with honest full, empty and fill count
// assumes one clock; push on full and pop on empty are ignored
module dcs_fifo
	import dcs_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// write side
	input  wire logic                       push,
	input  wire logic [WIDTH-1:0]           wdata,
	output logic                            full,
	// read side
	input  wire logic                       pop,
	output logic [WIDTH-1:0]                rdata,
	output logic                            empty,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [$clog2(DEPTH+1)-1:0] count_reg;
	logic             do_push;
	logic             do_pop;

	assign full    = (count_reg == DEPTH[$clog2(DEPTH+1)-1:0]);
	assign empty   = (count_reg == '0);
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign rdata   = mem[rd_ptr_reg];
	assign count   = count_reg;

	always_ff @(posedge pclk) begin
		if (do_push)
			mem[wr_ptr_reg] <= wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (do_push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (do_pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			if (do_push && !do_pop)
				count_reg <= count_reg + 1'b1;
			else if (do_pop && !do_push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule

// >>> dcs_sync.sv
// dcs_sync: three-stage synchroniser for a pin input with second/third agreement
// assumes the pin is asynchronous to pclk
module dcs_sync (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pin and clean level
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;

	// the second and third stages must agree before the level moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_reg <= s3_reg;
		end
	end

	assign level = level_reg;
	assign rise  = (s2_reg == s3_reg) && s3_reg && !level_reg;

endmodule

// >>> dcs_sequencer.sv
// dcs_sequencer: command-mode sequencer of a serial display transcoder, apb register file,
// ordered command/turn-around dispatch, response queue, tear-effect frame gating
// assumes the link layer outside takes dispatched words with valid/ready and reports receive events
module dcs_sequencer
	import dcs_pkg::*;
#(
	parameter int TXQ_DEPTH = DCS_TXQ_DEPTH,
	parameter int RXQ_DEPTH = DCS_RXQ_DEPTH
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// command dispatch toward the link
	output logic             tx_valid,
	output logic [31:0]      tx_data,
	output logic             tx_bta,
	input  wire logic        tx_ready,
	// link receive events
	input  wire logic        rx_hdr_valid,
	input  wire logic [31:0] rx_hdr,
	input  wire logic        rx_pyld_valid,
	input  wire logic [31:0] rx_pyld,
	input  wire logic        rx_trigger,
	input  wire logic        rx_te_trigger,
	input  wire logic        rx_err_valid,
	input  wire logic [15:0] rx_err,
	input  wire logic        bta_done,
	input  wire logic        bta_terminated,
	// video timing and pin
	input  wire logic        vblank_line_start,
	input  wire logic        te_gpio_pin,
	// frame engine
	output logic             frame_start,
	output logic             video_run,
	input  wire logic        frame_done,
	output logic             irq_pending
);

	////////////////////////////////////////////////////////////////////////
	// register state

	logic [31:0] imr_reg;
	logic [31:0] iir_reg;
	logic [3:0]  func_ctl_reg;
	logic        trans_en_reg;
	logic        no_unload_reg;
	logic        frm_req_reg;
	logic        periodic_reg;
	logic        in_prog0_reg;
	logic        in_prog1_reg;
	logic        te_seen_reg;
	logic        link_back_reg;
	logic        bta_armed_reg;
	logic [31:0] rx_hdr_reg;
	logic [31:0] prdata_reg;
	dcs_state_t  state_reg;
	dcs_state_t  state_next;

	logic wr_en;
	logic rd_en;
	logic eff_te_gpio;
	logic eff_gating;
	logic te_event;
	logic gpio_rise;
	logic frame_kick;
	logic [31:0] irq_set;

	logic                            txq_push;
	logic [DCS_TXQ_WIDTH-1:0]        txq_rdata;
	logic                            txq_empty;
	logic                            txq_full;
	logic                            rxq_pop;
	logic [31:0]                     rxq_rdata;
	logic                            rxq_empty;
	logic [$clog2(RXQ_DEPTH+1)-1:0]  rxq_count;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = prdata_reg;

	////////////////////////////////////////////////////////////////////////
	// shared command queue keeps header writes and turn-arounds in order

	// a turn-around rides the same queue as headers, so order is kept
	assign txq_push = wr_en && (paddr == DCS_OFF_CMD_HDR ||
		(paddr == DCS_OFF_LP_MSG && pwdata[DCS_LP_BTA]));

	dcs_fifo #(
		.WIDTH (DCS_TXQ_WIDTH),
		.DEPTH (TXQ_DEPTH)
	) u_txq (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (txq_push),
		.wdata   ({paddr == DCS_OFF_LP_MSG, pwdata}),
		.full    (txq_full),
		.pop     (tx_valid && tx_ready),
		.rdata   (txq_rdata),
		.empty   (txq_empty),
		.count   ()
	);

	// turn-around in video mode only at a vertical blank line start, never the read's line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bta_armed_reg <= 1'b0;
		else if (tx_valid && tx_ready)
			bta_armed_reg <= 1'b0;
		else if (vblank_line_start && !txq_empty && txq_rdata[32])
			bta_armed_reg <= 1'b1;
	end

	assign tx_data  = txq_rdata[31:0];
	assign tx_bta   = txq_rdata[32];
	assign tx_valid = !txq_empty && trans_en_reg &&
		(!txq_rdata[32] || func_ctl_reg[DCS_FC_CMD_MODE] || bta_armed_reg);

	////////////////////////////////////////////////////////////////////////
	// response queue and header register

	assign rxq_pop = rd_en && paddr == DCS_OFF_RX_PYLD && !no_unload_reg;

	dcs_fifo #(
		.WIDTH (32),
		.DEPTH (RXQ_DEPTH)
	) u_rxq (
		.pclk    (pclk),
		.presetn (presetn),
		.push    (rx_pyld_valid),
		.wdata   (rx_pyld),
		.full    (),
		.pop     (rxq_pop),
		.rdata   (rxq_rdata),
		.empty   (rxq_empty),
		.count   (rxq_count)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_hdr_reg <= DCS_ZERO_RESET;
		else if (rx_hdr_valid)
			rx_hdr_reg <= rx_hdr;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: event bits gated by mask, set wins over write-one-clear

	always_comb begin
		irq_set = '0;
		if (rx_err_valid)
			irq_set[15:0] = rx_err;
		irq_set[DCS_IRQ_RX_TRIG] = rx_trigger && !rx_te_trigger;
		irq_set[DCS_IRQ_RX_DATA] = rx_hdr_valid || rx_pyld_valid || bta_terminated;
		irq_set = irq_set & ~imr_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			iir_reg <= DCS_ZERO_RESET;
		else if (wr_en && paddr == DCS_OFF_IIR)
			iir_reg <= (iir_reg & ~pwdata) | irq_set;
		else
			iir_reg <= iir_reg | irq_set;
	end

	assign irq_pending = |iir_reg;

	////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imr_reg       <= DCS_IMR_RESET;
			func_ctl_reg  <= '0;
			trans_en_reg  <= 1'b0;
			no_unload_reg <= 1'b0;
			periodic_reg  <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				DCS_OFF_IMR:       imr_reg       <= pwdata;
				DCS_OFF_FUNC_CTL:  func_ctl_reg  <= pwdata[3:0];
				DCS_OFF_TRANS_CFG: trans_en_reg  <= pwdata[DCS_TC_ENABLE];
				DCS_OFF_RX_CTL:    no_unload_reg <= pwdata[DCS_RC_NO_UNLOAD];
				DCS_OFF_FRM_CTL0:  periodic_reg  <= pwdata[DCS_FR_PERIODIC];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tear-effect source and overrides

	dcs_sync u_te_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (te_gpio_pin),
		.level   (),
		.rise    (gpio_rise)
	);

	// periodic mode cannot issue turn-arounds, so it forces gpio tear and non-gating
	assign eff_te_gpio = func_ctl_reg[DCS_FC_TE_GPIO] || periodic_reg;
	assign eff_gating  = func_ctl_reg[DCS_FC_GATING] && !periodic_reg;
	assign te_event    = eff_te_gpio ? gpio_rise : rx_te_trigger;

	////////////////////////////////////////////////////////////////////////
	// frame sequencer

	assign frame_kick = frm_req_reg || (periodic_reg && te_event);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DCS_ST_OFF:
				if (trans_en_reg)
					state_next = func_ctl_reg[DCS_FC_CMD_MODE] ? DCS_ST_IDLE : DCS_ST_VIDEO;
			DCS_ST_IDLE:
				if (!trans_en_reg)
					state_next = DCS_ST_OFF;
				else if (frame_kick)
					state_next = eff_gating ? DCS_ST_WAIT_TE : DCS_ST_SEND;
			DCS_ST_WAIT_TE:
				if (!trans_en_reg)
					state_next = DCS_ST_OFF;
				else if ((te_seen_reg || te_event) &&
					(eff_te_gpio || link_back_reg || bta_done))
					state_next = DCS_ST_SEND;
			DCS_ST_WAIT_BTA:
				state_next = DCS_ST_SEND;
			DCS_ST_SEND:
				if (frame_done)
					state_next = trans_en_reg ? DCS_ST_IDLE : DCS_ST_OFF;
			DCS_ST_VIDEO:
				if (!trans_en_reg && frame_done)
					state_next = DCS_ST_OFF;
			default:
				state_next = DCS_ST_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= DCS_ST_OFF;
		else
			state_reg <= state_next;
	end

	// tear event and returned link control may come in either order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			te_seen_reg   <= 1'b0;
			link_back_reg <= 1'b0;
		end else if (state_reg != DCS_ST_WAIT_TE) begin
			te_seen_reg   <= 1'b0;
			link_back_reg <= 1'b0;
		end else begin
			if (te_event)
				te_seen_reg <= 1'b1;
			if (bta_done)
				link_back_reg <= 1'b1;
		end
	end

	// frame request: set by port 0 write only, cleared when taken; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frm_req_reg <= 1'b0;
		else if (wr_en && paddr == DCS_OFF_FRM_CTL0 && pwdata[DCS_FR_REQ])
			frm_req_reg <= 1'b1;
		else if (state_reg == DCS_ST_IDLE && trans_en_reg)
			frm_req_reg <= 1'b0;
	end

	// port 1 follows port 0 one cycle later, or rises with it in dual-link mode, so it never reads idle early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_prog0_reg <= 1'b0;
			in_prog1_reg <= 1'b0;
		end else begin
			in_prog0_reg <= (state_next == DCS_ST_WAIT_TE || state_next == DCS_ST_SEND);
			in_prog1_reg <= in_prog0_reg || (func_ctl_reg[DCS_FC_DUAL_LINK] &&
				(state_next == DCS_ST_WAIT_TE || state_next == DCS_ST_SEND));
		end
	end

	assign frame_start = (state_reg != DCS_ST_SEND) && (state_next == DCS_ST_SEND);
	assign video_run   = (state_reg == DCS_ST_VIDEO);

	////////////////////////////////////////////////////////////////////////
	// apb read mux

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= DCS_ZERO_RESET;
		else if (psel && !penable && !pwrite) begin
			prdata_reg <= '0;
			case (paddr)
				DCS_OFF_LP_MSG:    prdata_reg[DCS_LP_BTA] <= !txq_empty && txq_rdata[32];
				DCS_OFF_RX_HDR:    prdata_reg <= rx_hdr_reg;
				DCS_OFF_RX_PYLD:   prdata_reg <= rxq_empty ? '0 : rxq_rdata;
				DCS_OFF_RX_CTL:    prdata_reg <= {{(24-$bits(rxq_count)){1'b0}}, rxq_count,
					7'h00, no_unload_reg};
				DCS_OFF_FRM_CTL0:  prdata_reg[2:0] <= {in_prog0_reg, periodic_reg, frm_req_reg};
				DCS_OFF_FRM_CTL1:  prdata_reg[DCS_FR_IN_PROG] <= in_prog1_reg;
				DCS_OFF_FUNC_CTL:  prdata_reg[3:0] <= func_ctl_reg;
				DCS_OFF_TRANS_CFG: prdata_reg[1:0] <= {state_reg != DCS_ST_OFF, trans_en_reg};
				DCS_OFF_IMR:       prdata_reg <= imr_reg;
				DCS_OFF_IIR:       prdata_reg <= iir_reg;
				default:           prdata_reg <= '0;
			endcase
		end
	end

endmodule

// >>> dcs_chk.sv
// dcs_chk: port-level assertions for the command-mode sequencer
// assumes apb writes land at the access edge and the link side pulses events for one cycle
module dcs_chk
	import dcs_pkg::*;
(
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// dispatch
	input wire logic        tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic        tx_bta,
	input wire logic        tx_ready,
	// receive events
	input wire logic        rx_hdr_valid,
	input wire logic        rx_pyld_valid,
	input wire logic        rx_trigger,
	input wire logic        rx_te_trigger,
	input wire logic        rx_err_valid,
	input wire logic [15:0] rx_err,
	input wire logic        bta_terminated,
	// frame engine
	input wire logic        frame_start,
	input wire logic        frame_done,
	input wire logic        video_run,
	input wire logic        irq_pending
);
	logic [31:0] imr_reg;
	logic [3:0]  fc_reg;
	logic        en_reg;
	logic        per_reg;
	logic        busy_reg;
	wire         wr = psel && penable && pwrite;

	////////////////////////////////////////////////////////////////////////
	// shadows of the software settings and of frame activity, so masks, modes and busy are known here
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) imr_reg <= DCS_IMR_RESET;
		else if (wr && paddr == DCS_OFF_IMR) imr_reg <= pwdata;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) fc_reg <= 4'h0;
		else if (wr && paddr == DCS_OFF_FUNC_CTL) fc_reg <= pwdata[3:0];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) en_reg <= 1'b0;
		else if (wr && paddr == DCS_OFF_TRANS_CFG) en_reg <= pwdata[DCS_TC_ENABLE];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) per_reg <= 1'b0;
		else if (wr && paddr == DCS_OFF_FRM_CTL0) per_reg <= pwdata[DCS_FR_PERIODIC];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) busy_reg <= 1'b0;
		else if (frame_start) busy_reg <= 1'b1;
		else if (frame_done) busy_reg <= 1'b0;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_answer: assert property (pready && !pslverr) else $error("apb answer not ready or error");
	a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside a setup");
	a_head_hold: assert property (tx_valid && !tx_ready && !wr |=> tx_valid && $stable(tx_data) && $stable(tx_bta))
		else $error("queue head changed before taken");
	a_frame_excl: assert property (frame_start && !video_run |-> !busy_reg)
		else $error("frame started while another runs");
	a_nongate_go: assert property (wr && paddr == DCS_OFF_FRM_CTL0 && pwdata[DCS_FR_REQ] && fc_reg[DCS_FC_CMD_MODE]
		&& !fc_reg[DCS_FC_GATING] && en_reg && !busy_reg && !per_reg |-> ##[1:3] frame_start)
		else $error("non-gating request did not start a frame");
	a_trig_irq: assert property (rx_trigger && !rx_te_trigger && !imr_reg[DCS_IRQ_RX_TRIG] |=> irq_pending)
		else $error("trigger did not raise interrupt");
	a_data_irq: assert property ((rx_hdr_valid || bta_terminated) && !imr_reg[DCS_IRQ_RX_DATA] |=> irq_pending)
		else $error("response did not raise interrupt");
	a_err_log: assert property (rx_err_valid && (rx_err & ~imr_reg[15:0]) != 16'h0000 |=> irq_pending)
		else $error("unmasked panel error not logged");
	a_iir_clear: assert property (wr && paddr == DCS_OFF_IIR && pwdata == 32'hFFFFFFFF && !rx_hdr_valid
		&& !rx_trigger && !rx_err_valid && !bta_terminated && !rx_pyld_valid |=> !irq_pending)
		else $error("interrupt not cleared by write");

	c_frame: cover property (frame_start);
	c_bta: cover property (tx_valid && tx_ready && tx_bta);
	c_err: cover property (rx_err_valid);
endmodule

bind dcs_sequencer dcs_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_bta(tx_bta), .tx_ready(tx_ready),
	.rx_hdr_valid(rx_hdr_valid), .rx_trigger(rx_trigger), .rx_te_trigger(rx_te_trigger),
	.rx_err_valid(rx_err_valid), .rx_err(rx_err), .bta_terminated(bta_terminated), .rx_pyld_valid(rx_pyld_valid),
	.frame_start(frame_start), .frame_done(frame_done), .video_run(video_run), .irq_pending(irq_pending));

// >>> dcs_panel.sv
// dcs_panel: behavioural panel on the far side of the link
// assumes ev() is called right after a rising edge
module dcs_panel (
	// dispatch from the host
	input  wire logic        pclk,
	input  wire logic        slow,
	input  wire logic        tx_valid,
	input  wire logic [31:0] tx_data,
	input  wire logic        tx_bta,
	output logic             tx_ready,
	// events toward the host
	output logic             rx_hdr_valid,
	output logic [31:0]      rx_hdr,
	output logic             rx_pyld_valid,
	output logic [31:0]      rx_pyld,
	output logic             rx_trigger,
	output logic             rx_te_trigger,
	output logic             rx_err_valid,
	output logic [15:0]      rx_err,
	output logic             bta_done,
	output logic             bta_terminated
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] logd[$];
	logic        logb[$];
	int          bta_cnt = 0;

	initial begin
		{tx_ready, rx_hdr_valid, rx_pyld_valid, rx_trigger, rx_te_trigger} = 5'h00;
		{rx_err_valid, bta_done, bta_terminated} = 3'h0;
		{rx_hdr, rx_pyld, rx_err} = 80'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// a slow panel stalls every other cycle, so the head has to wait
	always @(posedge pclk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			logd.push_back(tx_data);
			logb.push_back(tx_bta);
		end
		bta_cnt <= (tx_valid && tx_ready && tx_bta) ? 3 : (bta_cnt > 0 ? bta_cnt - 1 : 0);
		bta_done <= (bta_cnt == 1);
	end

	// kinds: 0 header, 1 payload, 2 trigger, 3 tear trigger, 4 error report, 5 turn-around ended
	task automatic ev(input int k, input logic [31:0] d);
		@(posedge pclk);
		{rx_hdr, rx_pyld, rx_err} <= {d, d, d[15:0]};
		{rx_hdr_valid, rx_pyld_valid, rx_trigger} <= {k == 0, k == 1, k == 2};
		{rx_te_trigger, rx_err_valid, bta_terminated} <= {k == 3, k == 4, k == 5};
		@(posedge pclk);
		{rx_hdr_valid, rx_pyld_valid, rx_trigger, rx_te_trigger, rx_err_valid, bta_terminated} <= 6'h00;
		// released data lines show the inverse, not a held value
		{rx_hdr, rx_pyld, rx_err} <= {~d, ~d, ~d[15:0]};
	endtask
endmodule

// >>> tb.sv
// tb: self-checking bench of the command-mode sequencer
// assumes zero-wait apb and the panel model on the link side
module tb
	import dcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, tx_data, rx_hdr, rx_pyld;
	logic        tx_valid, tx_bta, tx_ready, rx_hdr_valid, rx_pyld_valid, rx_trigger, rx_te_trigger;
	logic        rx_err_valid, bta_done, bta_terminated, vblank_line_start, te_gpio_pin;
	logic        frame_start, video_run, frame_done, irq_pending;
	logic [15:0] rx_err;
	int          num_errors = 0;
	int          compares = 0;
	int          nfs = 0;

	dcs_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_bta(tx_bta), .tx_ready(tx_ready),
		.rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr), .rx_pyld_valid(rx_pyld_valid), .rx_pyld(rx_pyld),
		.rx_trigger(rx_trigger), .rx_te_trigger(rx_te_trigger), .rx_err_valid(rx_err_valid),
		.rx_err(rx_err), .bta_done(bta_done), .bta_terminated(bta_terminated),
		.vblank_line_start(vblank_line_start), .te_gpio_pin(te_gpio_pin), .frame_start(frame_start),
		.video_run(video_run), .frame_done(frame_done), .irq_pending(irq_pending));
	dcs_panel pnl (.pclk(pclk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data), .tx_bta(tx_bta),
		.tx_ready(tx_ready), .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr), .rx_pyld_valid(rx_pyld_valid),
		.rx_pyld(rx_pyld), .rx_trigger(rx_trigger), .rx_te_trigger(rx_te_trigger),
		.rx_err_valid(rx_err_valid), .rx_err(rx_err), .bta_done(bta_done), .bta_terminated(bta_terminated));

	always #5 pclk = ~pclk;
	always @(posedge pclk) if (frame_start === 1'b1) nfs <= nfs + 1;

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one full transfer; the idle cycle after it keeps each signal to one update per edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		bus(1'b1, a, wd, x);
	endtask
	task automatic fdone;
		frame_done <= 1'b1;
		@(posedge pclk);
		frame_done <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic off_wait;
		logic [31:0] d;
		int          n;
		n = 0;
		do begin
			bus(1'b0, DCS_OFF_TRANS_CFG, 32'h0, d);
			n++;
		end while (d[DCS_TC_STATE] !== 1'b0 && n < 20);
		chk({31'h0, d[DCS_TC_STATE]}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] d;
		bus(1'b0, DCS_OFF_IMR, 32'h0, d);
		chk(d, DCS_IMR_RESET);
		bus(1'b0, DCS_OFF_FRM_CTL0, 32'h0, d);
		chk(d, 32'h0);
		bus(1'b0, 8'hFC, 32'h0, d);
		chk(d, 32'h0);
	endtask
	task automatic t_order;
		wr(DCS_OFF_FUNC_CTL, 32'h4);
		wr(DCS_OFF_TRANS_CFG, 32'h1);
		slow <= 1'b1;
		wr(DCS_OFF_CMD_HDR, 32'h11110001);
		wr(DCS_OFF_LP_MSG, 32'h1);
		wr(DCS_OFF_CMD_HDR, 32'h22220002);
		cyc(12);
		chk(32'(pnl.logd.size()), 32'h3);
		chk(pnl.logd[0], 32'h11110001);
		chk({31'h0, pnl.logb[1]}, 32'h1);
		chk(pnl.logd[2], 32'h22220002);
		slow <= 1'b0;
		pnl.logd.delete();
	endtask
	task automatic t_video;
		wr(DCS_OFF_TRANS_CFG, 32'h0);
		off_wait;
		wr(DCS_OFF_FUNC_CTL, 32'h0);
		wr(DCS_OFF_TRANS_CFG, 32'h1);
		cyc(1);
		chk({31'h0, video_run}, 32'h1);
		wr(DCS_OFF_CMD_HDR, 32'h33330003);
		wr(DCS_OFF_LP_MSG, 32'h1);
		cyc(6);
		chk(32'(pnl.logd.size()), 32'h1);
		vblank_line_start <= 1'b1;
		@(posedge pclk);
		vblank_line_start <= 1'b0;
		cyc(6);
		chk(32'(pnl.logd.size()), 32'h2);
		wr(DCS_OFF_TRANS_CFG, 32'h0);
		fdone;
		off_wait;
		chk({31'h0, video_run}, 32'h0);
		wr(DCS_OFF_FUNC_CTL, 32'h4);
		wr(DCS_OFF_TRANS_CFG, 32'h1);
	endtask
	task automatic t_irq;
		logic [31:0] d;
		wr(DCS_OFF_IMR, 32'h000000FF);
		pnl.ev(4, 32'h00000F0F);
		pnl.ev(3, 32'h0);
		bus(1'b0, DCS_OFF_IIR, 32'h0, d);
		chk(d, 32'h00000F00);
		pnl.ev(2, 32'h0);
		pnl.ev(0, 32'h5A5A0001);
		bus(1'b0, DCS_OFF_IIR, 32'h0, d);
		chk(d, 32'h00030F00);
		bus(1'b0, DCS_OFF_RX_HDR, 32'h0, d);
		chk(d, 32'h5A5A0001);
		wr(DCS_OFF_IIR, 32'hFFFFFFFF);
		pnl.ev(5, 32'h0);
		bus(1'b0, DCS_OFF_IIR, 32'h0, d);
		chk(d, 32'h00020000);
		wr(DCS_OFF_IIR, 32'hFFFFFFFF);
		chk({31'h0, irq_pending}, 32'h0);
	endtask
	task automatic t_rxq;
		logic [31:0] d;
		for (int i = 0; i < 3; i++) pnl.ev(1, 32'hA0 + i);
		wr(DCS_OFF_RX_CTL, 32'h1);
		bus(1'b0, DCS_OFF_RX_PYLD, 32'h0, d);
		bus(1'b0, DCS_OFF_RX_PYLD, 32'h0, d);
		chk(d, 32'hA0);
		bus(1'b0, DCS_OFF_RX_CTL, 32'h0, d);
		chk({24'h0, d[15:8]}, 32'h3);
		wr(DCS_OFF_RX_CTL, 32'h0);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, DCS_OFF_RX_PYLD, 32'h0, d);
			chk(d, 32'hA0 + i);
		end
		bus(1'b0, DCS_OFF_RX_CTL, 32'h0, d);
		chk({24'h0, d[15:8]}, 32'h0);
	endtask
	task automatic t_frame;
		logic [31:0] d;
		int          n0;
		n0 = nfs;
		wr(DCS_OFF_FUNC_CTL, 32'hC);
		wr(DCS_OFF_FRM_CTL1, 32'h1);
		cyc(4);
		chk(32'(nfs - n0), 32'h0);
		wr(DCS_OFF_FRM_CTL0, 32'h1);
		bus(1'b0, DCS_OFF_FRM_CTL0, 32'h0, d);
		chk(d & 32'h5, 32'h4);
		bus(1'b0, DCS_OFF_FRM_CTL1, 32'h0, d);
		chk(d & 32'h4, 32'h4);
		chk(32'(nfs - n0), 32'h1);
		fdone;
		wr(DCS_OFF_FUNC_CTL, 32'h7);
		wr(DCS_OFF_FRM_CTL0, 32'h1);
		pnl.ev(3, 32'h0);
		cyc(6);
		chk(32'(nfs - n0), 32'h1);
		te_gpio_pin <= 1'b1;
		cyc(8);
		chk(32'(nfs - n0), 32'h2);
		te_gpio_pin <= 1'b0;
		fdone;
		wr(DCS_OFF_FUNC_CTL, 32'h6);
		wr(DCS_OFF_FRM_CTL0, 32'h1);
		cyc(6);
		chk(32'(nfs - n0), 32'h2);
		pnl.ev(3, 32'h0);
		wr(DCS_OFF_LP_MSG, 32'h1);
		cyc(12);
		chk(32'(nfs - n0), 32'h3);
		fdone;
	endtask
	task automatic t_periodic;
		int n0;
		n0 = nfs;
		wr(DCS_OFF_FRM_CTL0, 32'h2);
		pnl.ev(3, 32'h0);
		cyc(6);
		chk(32'(nfs - n0), 32'h0);
		for (int i = 1; i < 3; i++) begin
			te_gpio_pin <= 1'b1;
			cyc(8);
			chk(32'(nfs - n0), 32'(i));
			te_gpio_pin <= 1'b0;
			fdone;
			cyc(2);
		end
		wr(DCS_OFF_FRM_CTL0, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
		{vblank_line_start, te_gpio_pin, frame_done} = 3'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_order;
		t_video;
		t_irq;
		t_rxq;
		t_frame;
		t_periodic;
		end_sim;
	end
	// watchdog far beyond the few hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_sim;
	end
endmodule
